// File: hdl/ddscr_top.sv
// Control register bank of a direct digital synthesizer.
// Assumes the host port, parallel data pins and function_select_pins are
// timed to ref_clk; update, profile and lock pins are asynchronous.
//
// Contract
// - Writes staged, applied on update or profile
// - Serial addresses 0x00 to 0x1B decode
// - Parallel bytes 112, little-endian per word
// - Master reset restores every default value
// - Control bit 24 rising starts PLL calibration
// - Bit 17 low: port words on update
// - Bit 17 high: sample every edge
// - Bit 16 selects sine, default sine
// - Phase offset in bytes 0x68, 0x69
// - Amplitude scale twelve bits, 0x6A/0x6B
// - Autoclear resets accumulator on each update
`timescale 1ns/1ns
`default_nettype none
module ddscr_top
  import ddscr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Host register port
  input wire ddscr_req_s req,
  output logic [31:0] rdata,
  output logic rvalid,
  // Asynchronous pins
  input wire logic update_pin,
  input wire logic [2:0] profile_pins,
  input wire logic pll_lock_pin,
  // 32-bit parallel data port
  input wire logic [31:0] par_data,
  input wire logic [3:0] function_select_pins,
  output logic par_ready,
  // Words toward the synthesizer core
  output logic word_valid,
  input wire logic word_ready,
  output ddscr_word_s word_out,
  // Applied control state
  output logic sine_select,
  output logic stream_enable,
  output logic pll_cal_start,
  output logic phase_acc_clear,
  output logic conv_cal_enable,
  output logic [15:0] phase_offset_word,
  output logic [11:0] amplitude_word
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [4:0] pins_s; // Filtered asynchronous pins
  logic upd_prev_r; // Update level last cycle
  logic [2:0] prof_prev_r; // Profile pins last cycle
  logic [31:0] ctrl_stage_r; // Written, not yet applied
  logic [31:0] prof_stage_r;
  logic [31:0] user_stage_r;
  logic [31:0] ctrl_act_r; // Applied copies
  logic [31:0] prof_act_r;
  logic [31:0] user_act_r;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic cal_r;
  logic aclr_r;
  logic push_valid;
  ddscr_word_s push_word;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Shared by write and read paths
  function automatic ddscr_sel_e reg_sel(input logic [4:0] idx, input logic ok);
    ddscr_sel_e s;
    s = DDSCR_SEL_NONE;
    if (ok)
    begin
      case (idx)
        DDSCR_IDX_CTRL: s = DDSCR_SEL_CTRL;
        DDSCR_IDX_PROF: s = DDSCR_SEL_PROF;
        DDSCR_IDX_USER: s = DDSCR_SEL_USER;
        default: s = DDSCR_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  wire ser_ok = (req.addr[6:5] == 2'b00) && (req.addr[4:0] <= DDSCR_LAST_WORD);
  wire par_ok = (req.addr <= DDSCR_LAST_BYTE);
  wire addr_ok = req.par_mode ? par_ok : ser_ok;
  // Four parallel bytes per serial word
  wire [4:0] word_idx = req.par_mode ? req.addr[6:2] : req.addr[4:0];
  wire [1:0] lane = req.addr[1:0];
  wire ddscr_sel_e sel = reg_sel(word_idx, addr_ok);
  // Lowest address holds least significant byte
  wire [31:0] lane_mask = 32'h0000_00FF << {lane, 3'b000};
  wire [31:0] byte_mask = req.par_mode ? lane_mask : 32'hFFFF_FFFF;
  wire [31:0] shifted_wd = req.par_mode ? ({24'h00_0000, req.wdata[7:0]} << {lane, 3'b000}) : req.wdata;
  wire do_wr = req.wr && ce;
  wire do_rd = req.rd && ce;
  // Merged write values; open bits are masked off
  // Open bits ignore writes
  wire [31:0] ctrl_wnew = ((ctrl_stage_r & ~byte_mask) | (shifted_wd & byte_mask)) & DDSCR_CTRL_MASK;
  // Phase offset low half, amplitude upper half
  wire [31:0] prof_wnew = ((prof_stage_r & ~byte_mask) | (shifted_wd & byte_mask)) & DDSCR_PROF_MASK;
  // Lock bit excluded from write mask
  wire [31:0] user_wnew = ((user_stage_r & ~byte_mask) | (shifted_wd & byte_mask)) & DDSCR_USER_MASK;

  // ----------------------------------------
  // Pin synchronisation and update event
  // ----------------------------------------
  ddscr_sync #(
    .WIDTH(5)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .pin_in({pll_lock_pin, profile_pins, update_pin}),
    .sync_out(pins_s)
  );
  wire upd_s = pins_s[0];
  wire [2:0] prof_s = pins_s[3:1];
  wire lock_s = pins_s[4];
  // Update rise or any profile change
  wire apply_evt = ce && ((upd_s && !upd_prev_r) || (prof_s != prof_prev_r));

  // Edge detectors on filtered pins
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      upd_prev_r <= 1'b0;
      prof_prev_r <= 3'b000;
    end
    else if (ce)
    begin
      upd_prev_r <= upd_s;
      prof_prev_r <= prof_s;
    end
  end

  // ----------------------------------------
  // Staging registers
  // ----------------------------------------
  // Host writes land here; nothing downstream sees them yet
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_stage_r <= DDSCR_CTRL_RST;
      prof_stage_r <= DDSCR_PROF_RST;
      user_stage_r <= DDSCR_USER_RST;
    end
    else if (do_wr)
    begin
      case (sel)
        DDSCR_SEL_CTRL: ctrl_stage_r <= ctrl_wnew;
        DDSCR_SEL_PROF: prof_stage_r <= prof_wnew;
        DDSCR_SEL_USER: user_stage_r <= user_wnew;
        default:
        begin
          // Words outside this bank are dropped
        end
      endcase
    end
  end

  // ----------------------------------------
  // Applied registers
  // ----------------------------------------
  // A write landing in the same cycle as the event waits for the next one;
  // the staged copy is what the event moves.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_act_r <= DDSCR_CTRL_RST;
      prof_act_r <= DDSCR_PROF_RST;
      user_act_r <= DDSCR_USER_RST;
    end
    else if (apply_evt)
    begin
      ctrl_act_r <= ctrl_stage_r;
      prof_act_r <= prof_stage_r;
      user_act_r <= user_stage_r;
    end
  end

  // ----------------------------------------
  // Calibration start and accumulator clear
  // ----------------------------------------
  // Both are one-cycle pulses tied to the event
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cal_r <= 1'b0;
      aclr_r <= 1'b0;
    end
    else if (ce)
    begin
      // Fresh rise of bit 24 only
      // Bit held high gives no retrigger
      cal_r <= apply_evt && ctrl_stage_r[DDSCR_BIT_PLL_CAL] && !ctrl_act_r[DDSCR_BIT_PLL_CAL];
      aclr_r <= apply_evt && ctrl_stage_r[DDSCR_BIT_AUTOCLR];
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Reads return the staged value so a host can verify before updating
  wire [31:0] lock_word = {7'h00, lock_s, 24'h00_0000};
  wire [31:0] rd_word =
    (sel == DDSCR_SEL_CTRL) ? ctrl_stage_r :
    (sel == DDSCR_SEL_PROF) ? prof_stage_r :
    (sel == DDSCR_SEL_USER) ? (user_stage_r | lock_word) : 32'h0000_0000;
  wire [31:0] rd_byte = {24'h00_0000, 8'((rd_word >> {lane, 3'b000}))};

  // Read data registered one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end
    else if (ce)
    begin
      rvalid_r <= do_rd;
      if (do_rd)
        rdata_r <= req.par_mode ? rd_byte : rd_word;
    end
  end

  // ----------------------------------------
  // Parallel data path
  // ----------------------------------------
  wire fsel_freq = (function_select_pins == DDSCR_FSEL_FREQ);
  wire fsel_phase = (function_select_pins == DDSCR_FSEL_PHASE);
  wire fsel_amp = (function_select_pins == DDSCR_FSEL_AMP);
  wire fsel_ok = fsel_freq || fsel_phase || fsel_amp;
  wire streaming = ctrl_act_r[DDSCR_BIT_STREAM];
  assign push_valid = fsel_ok && (streaming || apply_evt);
  assign push_word.dest = fsel_phase ? DDSCR_DEST_PHASE : (fsel_amp ? DDSCR_DEST_AMP : DDSCR_DEST_FREQ);
  assign push_word.data = par_data;

  // A stalled core fills the buffer; par_ready then tells the host to hold
  ddscr_buf u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .in_valid(push_valid),
    .in_ready(par_ready),
    .in_data(push_word),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_out)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign sine_select = ctrl_act_r[DDSCR_BIT_SINE];
  assign stream_enable = streaming;
  assign pll_cal_start = cal_r;
  assign phase_acc_clear = aclr_r;
  // Host sets then clears this bit to run converter timing calibration
  assign conv_cal_enable = user_act_r[DDSCR_BIT_CONV_CAL];
  assign phase_offset_word = prof_act_r[15:0];
  assign amplitude_word = prof_act_r[27:16];
endmodule
`default_nettype wire

// File: hdl/ddscr_pkg.sv
// Package of the synthesizer control register bank: offsets, masks, defaults.
// Assumes the host port and data pins are timed to ref_clk (the sync clock).
package ddscr_pkg;
  // ----------------------------------------
  // Map sizes and word indices
  // ----------------------------------------
  localparam logic [4:0] DDSCR_LAST_WORD = 5'h1B; // Top serial address
  localparam logic [6:0] DDSCR_LAST_BYTE = 7'h6F; // Top parallel address
  localparam logic [4:0] DDSCR_IDX_CTRL = 5'h00; // control_function_one
  localparam logic [4:0] DDSCR_IDX_PROF = 5'h1A; // profile_last_phase_amplitude
  localparam logic [4:0] DDSCR_IDX_USER = 5'h1B; // user_calibration_lock
  // ----------------------------------------
  // Control bit positions
  // ----------------------------------------
  localparam int DDSCR_BIT_PLL_CAL = 24; // pll_calibration_start
  localparam int DDSCR_BIT_STREAM = 17; // Parallel streaming enable
  localparam int DDSCR_BIT_SINE = 16; // Sine (1) or cosine (0)
  localparam int DDSCR_BIT_AUTOCLR = 13; // Phase accumulator autoclear
  localparam int DDSCR_BIT_CONV_CAL = 0; // Converter calibration enable (user)
  localparam int DDSCR_BIT_LOCK = 24; // PLL lock, read only (user)
  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [31:0] DDSCR_CTRL_MASK = 32'h0103_FBFF; // Open bits stay zero
  localparam logic [31:0] DDSCR_PROF_MASK = 32'h0FFF_FFFF; // Top nibble open
  localparam logic [31:0] DDSCR_USER_MASK = 32'h00FF_FF7F; // Reserved, open, lock
  localparam logic [31:0] DDSCR_CTRL_RST = 32'h0001_0000; // Sine selected
  localparam logic [31:0] DDSCR_PROF_RST = 32'h0000_0000;
  localparam logic [31:0] DDSCR_USER_RST = 32'h0000_0800; // Second byte 0x08
  // ----------------------------------------
  // Register select codes and stream destinations
  // ----------------------------------------
  typedef enum logic [1:0] {DDSCR_SEL_NONE, DDSCR_SEL_CTRL, DDSCR_SEL_PROF, DDSCR_SEL_USER} ddscr_sel_e;
  localparam logic [3:0] DDSCR_FSEL_FREQ = 4'h0; // function_select_pins codes
  localparam logic [3:0] DDSCR_FSEL_PHASE = 4'h1;
  localparam logic [3:0] DDSCR_FSEL_AMP = 4'h2;
  typedef enum logic [1:0] {DDSCR_DEST_FREQ, DDSCR_DEST_PHASE, DDSCR_DEST_AMP} ddscr_dest_e;
  // Host register access, one per cycle
  typedef struct packed {
    logic wr; // Write strobe
    logic rd; // Read strobe
    logic par_mode; // 1: byte address, 0: word address
    logic [6:0] addr; // Byte or word address
    logic [31:0] wdata; // Byte in [7:0] in parallel mode
  } ddscr_req_s;
  // Word headed for the synthesizer core
  typedef struct packed {
    ddscr_dest_e dest; // frequency_tuning_word, phase_offset_word, amplitude_word
    logic [31:0] data;
  } ddscr_word_s;
endpackage

// File: hdl/ddscr_sync.sv
// Three-stage pin synchronizer with agreement filter.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module ddscr_sync
  import ddscr_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  // Stage one is read only by stage two
  logic [WIDTH-1:0] st1_r;
  logic [WIDTH-1:0] st2_r;
  logic [WIDTH-1:0] st3_r;
  // ----------------------------------------
  // Per-bit chain; output moves once stages two and three agree
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_bit
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          st1_r[gi] <= 1'b0;
          st2_r[gi] <= 1'b0;
          st3_r[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end
        else if (ce)
        begin
          st1_r[gi] <= pin_in[gi];
          st2_r[gi] <= st1_r[gi];
          st3_r[gi] <= st2_r[gi];
          // Agreement rejects a single-cycle glitch
          if (st2_r[gi] == st3_r[gi])
            sync_out[gi] <= st3_r[gi];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: hdl/ddscr_buf.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes producer and consumer share ref_clk.
`timescale 1ns/1ns
`default_nettype none
module ddscr_buf
  import ddscr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire ddscr_word_s in_data,
  output logic out_valid,
  input wire logic out_ready,
  output ddscr_word_s out_data
);
  // Storage and pointers
  ddscr_word_s mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  wire push = in_valid && in_ready && ce;
  wire pop = out_valid && out_ready && ce;
  // Honest flags straight from the count
  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  // Head comes from a flop, never from the input
  assign out_data = mem_r[rp_r];
  // ----------------------------------------
  // Pointer and count update
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  // Data array needs no reset
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
endmodule
`default_nettype wire

// File: testbench/ddscr_top_properties.sv
// Port checker for the synthesizer control register bank.
// Assumes it is bound to ddscr_top and that ce is held high.
`timescale 1ns/1ns
`default_nettype none
module ddscr_top_properties
  import ddscr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire ddscr_req_s req,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic update_pin,
  input wire logic [2:0] profile_pins,
  input wire logic pll_lock_pin,
  input wire logic [31:0] par_data,
  input wire logic [3:0] function_select_pins,
  input wire logic par_ready,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire ddscr_word_s word_out,
  input wire logic sine_select,
  input wire logic stream_enable,
  input wire logic pll_cal_start,
  input wire logic phase_acc_clear,
  input wire logic conv_cal_enable,
  input wire logic [15:0] phase_offset_word,
  input wire logic [11:0] amplitude_word
);
  // ----------------------------------------
  // Helper: cycles since a pin last moved
  // ----------------------------------------
  // Saturates, so long quiet spells stay at 4'hF
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  assign quiet_nxt = (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
  // Synchronizer delay means changes show up within ten cycles
  always_ff @(posedge ref_clk)
  begin
    if (rst || $changed(update_pin) || $changed(profile_pins))
      quiet_r <= 4'h0;
    else
      quiet_r <= quiet_nxt;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rd_alone;
    (ce && req.rd) ##1 !(ce && req.rd);
  endsequence
  sequence s_pulse_once;
    rvalid ##1 !rvalid;
  endsequence
  property p_rd;
    s_rd_alone |-> s_pulse_once;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer not a single pulse");
  property p_ser_oor;
    ce && req.rd && !req.par_mode && req.addr > 7'h1B |=> rdata == 32'h0000_0000;
  endproperty
  a_ser_oor: assert property (p_ser_oor) else $error("serial read past map not zero");
  property p_par_oor;
    ce && req.rd && req.par_mode && req.addr > 7'h6F |=> rdata == 32'h0000_0000;
  endproperty
  a_par_oor: assert property (p_par_oor) else $error("byte read past map not zero");
  property p_par_byte;
    ce && req.rd && req.par_mode |=> rdata[31:8] == 24'h00_0000;
  endproperty
  a_par_byte: assert property (p_par_byte) else $error("byte read upper bits set");
  property p_rst;
    disable iff (1'h0) rst && ce |=> sine_select && !word_valid && !rvalid && !stream_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_staged;
    $changed(sine_select) || $changed(stream_enable) |-> quiet_r < 4'hA;
  endproperty
  a_staged: assert property (p_staged) else $error("applied bit moved without update");
  property p_cal;
    pll_cal_start |-> quiet_r < 4'hA ##1 !pll_cal_start;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration pulse wrong");
  property p_clr;
    phase_acc_clear |-> quiet_r < 4'hA ##1 !phase_acc_clear;
  endproperty
  a_clr: assert property (p_clr) else $error("accumulator clear pulse wrong");
  property p_stream;
    stream_enable && ce && !word_valid && function_select_pins < 4'h3
      |=> word_valid && word_out.data == $past(par_data);
  endproperty
  a_stream: assert property (p_stream) else $error("stream sample missing");
  property p_nostream;
    !stream_enable && !word_valid && quiet_r == 4'hF |=> !word_valid;
  endproperty
  a_nostream: assert property (p_nostream) else $error("word without update");
  property p_hold;
    word_valid && !word_ready && ce |=> word_valid && $stable(word_out);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word lost");
  property p_open;
    ce && req.rd && !req.par_mode && req.addr == 7'h1B |=> (rdata & 32'hFE00_0080) == 32'h0000_0000;
  endproperty
  a_open: assert property (p_open) else $error("open user bits set");
endmodule
bind ddscr_top ddscr_top_properties u_props (.ref_clk(ref_clk), .rst(rst), .ce(ce), .req(req),
  .rdata(rdata), .rvalid(rvalid), .update_pin(update_pin), .profile_pins(profile_pins),
  .pll_lock_pin(pll_lock_pin), .par_data(par_data), .function_select_pins(function_select_pins),
  .par_ready(par_ready), .word_valid(word_valid), .word_ready(word_ready), .word_out(word_out),
  .sine_select(sine_select), .stream_enable(stream_enable), .pll_cal_start(pll_cal_start),
  .phase_acc_clear(phase_acc_clear), .conv_cal_enable(conv_cal_enable),
  .phase_offset_word(phase_offset_word), .amplitude_word(amplitude_word));
`default_nettype wire

// File: testbench/ddscr_host.sv
// Host controller model: register port and update/profile pins.
// Assumes ref_clk is the sync clock; every access is ready at once.
`timescale 1ns/1ns
`default_nettype none
module ddscr_host
  import ddscr_pkg::*;
(
  input wire logic ref_clk,
  output ddscr_req_s req,
  output logic update_pin,
  output logic [2:0] profile_pins,
  input wire logic [31:0] rdata
);
  initial
  begin
    req = '0;
    update_pin = 1'h0;
    profile_pins = 3'h0;
  end
  // Idle data is inverted so a stale value never looks fresh
  task automatic wr(input logic pm, input logic [6:0] a, input logic [31:0] d);
  begin
    @(posedge ref_clk);
    req <= {1'h1, 1'h0, pm, a, d};
    @(posedge ref_clk);
    req <= {1'h0, 1'h0, pm, a, ~d};
  end
  endtask
  // Read data is taken while rvalid stands
  task automatic rd(input logic pm, input logic [6:0] a, output logic [31:0] d);
  begin
    @(posedge ref_clk);
    req <= {1'h0, 1'h1, pm, a, ~req.wdata};
    @(posedge ref_clk);
    req.rd <= 1'h0;
    @(negedge ref_clk);
    d = rdata;
  end
  endtask
  // each level held at least four cycles
  task automatic upd();
  begin
    @(posedge ref_clk);
    update_pin <= 1'h1;
    repeat (4) @(posedge ref_clk);
    update_pin <= 1'h0;
    repeat (10) @(posedge ref_clk);
  end
  endtask
  task automatic prof();
  begin
    @(posedge ref_clk);
    profile_pins <= profile_pins + 3'h1;
    repeat (12) @(posedge ref_clk);
  end
  endtask
endmodule
`default_nettype wire

// File: testbench/ddscr_top_tb.sv
// Self-checking bench of the synthesizer control register bank.
// Assumes ddscr_host drives the register port and update/profile pins.
`timescale 1ns/1ns
`default_nettype none
module ddscr_top_tb;
  import ddscr_pkg::*;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  ddscr_req_s req;
  logic [31:0] rdata;
  logic rvalid;
  logic update_pin;
  logic [2:0] profile_pins;
  logic pll_lock_pin = 1'h0;
  logic [31:0] par_data = 32'h0000_0000;
  logic [3:0] fsel = 4'hF;
  logic par_ready;
  logic word_valid;
  logic word_ready = 1'h1;
  ddscr_word_s word_out;
  logic sine_select, stream_enable, pll_cal_start, phase_acc_clear, conv_cal_enable;
  logic [15:0] phase_offset_word;
  logic [11:0] amplitude_word;
  logic [31:0] d, b;
  integer seed, miscompares = 0, comparisons = 0, cycles = 0, cal_n = 0, clr_n = 0;
  ddscr_word_s q[$];
  ddscr_word_s exp_w;
  always #10 ref_clk = ~ref_clk;
  ddscr_host host (.ref_clk(ref_clk), .req(req), .update_pin(update_pin),
    .profile_pins(profile_pins), .rdata(rdata));
  ddscr_top dut (.ref_clk(ref_clk), .rst(rst), .ce(1'h1), .req(req), .rdata(rdata),
    .rvalid(rvalid), .update_pin(update_pin), .profile_pins(profile_pins),
    .pll_lock_pin(pll_lock_pin), .par_data(par_data), .function_select_pins(fsel),
    .par_ready(par_ready), .word_valid(word_valid), .word_ready(word_ready),
    .word_out(word_out), .sine_select(sine_select), .stream_enable(stream_enable),
    .pll_cal_start(pll_cal_start), .phase_acc_clear(phase_acc_clear),
    .conv_cal_enable(conv_cal_enable), .phase_offset_word(phase_offset_word),
    .amplitude_word(amplitude_word));
  function automatic ddscr_word_s exp_word(input logic [3:0] f, input logic [31:0] v);
    exp_word.dest = (f == DDSCR_FSEL_PHASE) ? DDSCR_DEST_PHASE :
      (f == DDSCR_FSEL_AMP) ? DDSCR_DEST_AMP : DDSCR_DEST_FREQ;
    exp_word.data = v;
  endfunction
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
  begin
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task automatic complete_run();
  begin
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // Pulse counters, timeout, and the word scoreboard at mid-cycle
  always @(posedge ref_clk)
  begin
    cycles++;
    cal_n += (pll_cal_start === 1'h1);
    clr_n += (phase_acc_clear === 1'h1);
    if (cycles == 8000)
    begin
      miscompares++;
      complete_run();
    end
  end
  always @(negedge ref_clk)
  begin
    if (word_valid === 1'h1 && word_ready === 1'h1)
    begin
      exp_w = (q.size() > 0) ? q.pop_front() : '1;
      check("word", word_out, exp_w);
    end
    if (stream_enable === 1'h1 && par_ready === 1'h1 && fsel < 4'h3)
      q.push_back(exp_word(fsel, par_data));
  end
  initial
  begin
    seed = 32'h921c;
    repeat (20) @(posedge ref_clk);
    rst <= 1'h0;
    host.rd(0, 7'h00, d);
    check("ctrl_rst", d, DDSCR_CTRL_RST);
    host.rd(0, 7'h1B, d);
    check("user_rst", d, DDSCR_USER_RST);
    check("sine_rst", sine_select, 1'h1);
    host.wr(0, 7'h00, 32'hFFFF_FFFF);
    host.rd(0, 7'h00, d);
    check("ctrl_mask", d, DDSCR_CTRL_MASK);
    check("staged", stream_enable, 1'h0);
    host.wr(0, 7'h00, 32'h0000_0000);
    host.upd();
    check("cosine", sine_select, 1'h0);
    // fixed bytes kept, every free bit set
    host.wr(0, 7'h1B, 32'hFF00_08FF);
    host.rd(0, 7'h1B, d);
    check("user_mask", d, 32'hFF00_08FF & DDSCR_USER_MASK);
    // pulse converter calibration, keep fixed bytes
    host.wr(0, 7'h1B, 32'h0000_0801);
    host.upd();
    check("conv_on", conv_cal_enable, 1'h1);
    host.wr(0, 7'h1B, 32'h0000_0800);
    host.upd();
    check("conv_off", conv_cal_enable, 1'h0);
    b = $random(seed);
    for (int i = 0; i < 4; i++)
      host.wr(1, 7'h68 + 7'(i), {24'h00_0000, b[8*i +: 8]});
    host.rd(0, 7'h1A, d);
    check("prof_word", d, b & DDSCR_PROF_MASK);
    host.rd(1, 7'h6B, d);
    check("amp_high", d, {28'h000_0000, b[27:24]});
    host.upd();
    check("phase", phase_offset_word, b[15:0]);
    check("amp", amplitude_word, b[27:16]);
    host.rd(0, 7'h1C, d);
    check("ser_oor", d, 32'h0000_0000);
    host.rd(1, 7'h70, d);
    check("par_oor", d, 32'h0000_0000);
    host.wr(0, 7'h00, 32'h0100_0000);
    host.prof();
    check("cal_one", cal_n, 1);
    host.prof();
    check("cal_held", cal_n, 1);
    host.wr(0, 7'h00, 32'h0000_0000);
    host.upd();
    host.wr(0, 7'h00, 32'h0100_2000);
    host.upd();
    host.upd();
    check("cal_two", cal_n, 2);
    check("clear_n", clr_n, 2);
    // Without streaming a port word enters only on update or profile change
    par_data <= $random(seed);
    fsel <= DDSCR_FSEL_PHASE;
    @(negedge ref_clk);
    q.push_back(exp_word(fsel, par_data));
    host.upd();
    fsel <= 4'hF;
    check("upd_word", q.size(), 0);
    host.wr(0, 7'h00, 32'h0002_0000);
    host.upd();
    check("stream_on", stream_enable, 1'h1);
    repeat (300)
    begin
      @(posedge ref_clk);
      par_data <= $random(seed);
      fsel <= 4'($random(seed) & 3);
      word_ready <= 1'($random(seed));
    end
    // Stalled consumer fills the buffer until it refuses
    @(posedge ref_clk);
    word_ready <= 1'h0;
    fsel <= DDSCR_FSEL_FREQ;
    repeat (4) @(posedge ref_clk);
    check("full", par_ready, 1'h0);
    fsel <= 4'hF;
    word_ready <= 1'h1;
    repeat (5) @(posedge ref_clk);
    check("drained", q.size(), 0);
    pll_lock_pin <= 1'h1;
    repeat (8) @(posedge ref_clk);
    host.rd(0, 7'h1B, d);
    check("lock", d[24], 1'h1);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    @(negedge ref_clk);
    check("sine_again", sine_select, 1'h1);
    check("stream_off", stream_enable, 1'h0);
    complete_run();
  end
endmodule
`default_nettype wire
